// ### logic/dc_sync_pulse_latch_regs.sv
// Sync pulse generation, start/cycle time and latch mode registers
`timescale 1ns/1ps
module dc_sync_pulse_latch_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [63:0] sys_time,
  input wire dc_sync_pkg::reg_req_s net_req,
  input wire logic net_frame_end,
  output logic [7:0] net_rdata,
  input wire dc_sync_pkg::reg_req_s host_req,
  output logic [7:0] host_rdata,
  input wire logic sync_owner_host,
  input wire logic latch_owner_host,
  input wire dc_sync_pkg::act_ctrl_s act_ctrl,
  input wire logic eeprom_len_load,
  input wire logic [15:0] eeprom_len,
  output logic first_sync_output,
  output logic second_sync_output,
  output logic unit_active,
  output logic [1:0] latch_capture_mode
);
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  logic [15:0] len_ff;
  logic [63:0] next0_ff;
  logic [63:0] next1_ff;
  logic [1:0] latch_ff;
  logic [7:0] start_b_ff [8];
  logic [7:0] cyc0_b_ff [4];
  logic [7:0] cyc1_b_ff [4];
  logic lo_wr_ff;
  logic hi_wr_ff;
  logic active_ff;
  logic auto_flag_ff;
  logic done0_ff;
  logic arm1_ff;
  logic force_ff;
  logic pend0_ff;
  logic pend1_ff;
  logic plaus_ff;
  logic [7:0] net_rdata_ff;
  logic [7:0] host_rdata_ff;

  logic sync_net_wr;
  logic sync_host_wr;
  logic latch_net_wr;
  logic latch_host_wr;
  assign sync_net_wr = net_req.wr && !sync_owner_host;
  assign sync_host_wr = host_req.wr && sync_owner_host;
  assign latch_net_wr = net_req.wr && !latch_owner_host;
  assign latch_host_wr = host_req.wr && latch_owner_host;

  dc_sync_pkg::reg_req_s cyc_req;
  logic cyc_wr;
  logic latch_wr;
  logic [7:0] latch_wdata;
  assign cyc_req = sync_owner_host ? host_req : net_req;
  assign cyc_wr = sync_net_wr || sync_host_wr;
  assign latch_wr = (latch_net_wr
    && net_req.addr == dc_sync_pkg::ADDR_LATCH_CTRL)
    || (latch_host_wr && host_req.addr == dc_sync_pkg::ADDR_LATCH_CTRL);
  assign latch_wdata = latch_host_wr ? host_req.wdata : net_req.wdata;

  logic start_hit;
  logic cyc0_hit;
  logic cyc1_hit;
  assign start_hit = sync_net_wr
    && net_req.addr[11:3] == dc_sync_pkg::ADDR_START_TIME[11:3];
  assign cyc0_hit = cyc_wr
    && cyc_req.addr[11:2] == dc_sync_pkg::ADDR_CYCLE0[11:2];
  assign cyc1_hit = cyc_wr
    && cyc_req.addr[11:2] == dc_sync_pkg::ADDR_CYCLE1[11:2];

  // byte lane i sits at base plus i
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_start
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          start_b_ff[gi] <= dc_sync_pkg::BYTE_RST;
        end else if (start_hit && net_req.addr[2:0] == 3'(gi)) begin
          start_b_ff[gi] <= net_req.wdata;
        end
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_cyc
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cyc0_b_ff[gi] <= dc_sync_pkg::BYTE_RST;
          cyc1_b_ff[gi] <= dc_sync_pkg::BYTE_RST;
        end else if (cyc_req.addr[1:0] == 2'(gi)) begin
          if (cyc0_hit) begin
            cyc0_b_ff[gi] <= cyc_req.wdata;
          end
          if (cyc1_hit) begin
            cyc1_b_ff[gi] <= cyc_req.wdata;
          end
        end
      end
    end
  endgenerate

  logic [63:0] start_sh;
  logic [31:0] cycle0;
  logic [31:0] cycle1;
  assign start_sh = {start_b_ff[7], start_b_ff[6], start_b_ff[5],
    start_b_ff[4], start_b_ff[3], start_b_ff[2], start_b_ff[1],
    start_b_ff[0]};
  assign cycle0 = {cyc0_b_ff[3], cyc0_b_ff[2], cyc0_b_ff[1], cyc0_b_ff[0]};
  assign cycle1 = {cyc1_b_ff[3], cyc1_b_ff[2], cyc1_b_ff[1], cyc1_b_ff[0]};

  // Commit at frame end so the halves of one frame act together
  logic commit;
  logic [31:0] ext_hi;
  logic [63:0] commit_time;
  logic lo_now;
  logic hi_now;
  assign lo_now = start_hit && !net_req.addr[2];
  assign hi_now = start_hit && net_req.addr[2];
  assign commit = net_frame_end && (lo_wr_ff || hi_wr_ff || start_hit);
  // carry upper half from system time
  assign ext_hi = sys_time[63:32]
    + 32'(start_sh[31:0] < sys_time[31:0]);
  assign commit_time = (act_ctrl.auto_act && !(hi_wr_ff || hi_now))
    ? {ext_hi, start_sh[31:0]} : start_sh;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_wr_ff <= 1'b0;
      hi_wr_ff <= 1'b0;
    end else if (net_frame_end) begin
      lo_wr_ff <= 1'b0;
      hi_wr_ff <= 1'b0;
    end else begin
      lo_wr_ff <= lo_wr_ff || lo_now;
      hi_wr_ff <= hi_wr_ff || hi_now;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_ff <= dc_sync_pkg::PULSE_LEN_RST;
    end else if (eeprom_len_load) begin
      len_ff <= eeprom_len;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= dc_sync_pkg::LATCH_CTRL_RST;
    end else if (latch_wr) begin
      latch_ff <= {latch_wdata[dc_sync_pkg::LATCH_NEG_BIT],
        latch_wdata[dc_sync_pkg::LATCH_POS_BIT]};
    end
  end

  logic nxt_auto_flag;
  logic nxt_active;
  logic active_rise;
  assign nxt_auto_flag = act_ctrl.auto_act && (auto_flag_ff || commit);
  assign nxt_active = act_ctrl.activate || auto_flag_ff;
  assign active_rise = nxt_active && !active_ff;

  logic [63:0] diff0;
  logic [63:0] diff1;
  logic [63:0] ahead;
  logic out_of_near;
  logic fire0;
  logic fire1;
  assign diff0 = sys_time - next0_ff;
  assign diff1 = sys_time - next1_ff;
  assign ahead = next0_ff - sys_time;
  // Long window is half the time range, i.e. the sign of the gap
  assign out_of_near = act_ctrl.near_short
    ? (ahead >= dc_sync_pkg::NEAR_SHORT_NS) : ahead[63];
  // fire when system time reaches next time
  assign fire0 = active_ff && act_ctrl.first_sync_en && !done0_ff
    && (!diff0[63] || force_ff);
  assign fire1 = active_ff && act_ctrl.second_sync_en && arm1_ff
    && !diff1[63];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_ff <= 1'b0;
      auto_flag_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active;
      auto_flag_ff <= nxt_auto_flag;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      next0_ff <= dc_sync_pkg::TIME_RST;
      done0_ff <= 1'b0;
    end else if (commit) begin
      next0_ff <= commit_time;
      done0_ff <= 1'b0;
    end else if (fire0) begin
      // zero cycle stops after one pulse
      if (cycle0 == dc_sync_pkg::CYCLE_RST) begin
        done0_ff <= 1'b1;
      end else begin
        next0_ff <= next0_ff + 64'(cycle0);
      end
    end
  end

  // second pulse follows first by delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      next1_ff <= dc_sync_pkg::TIME_RST;
      arm1_ff <= 1'b0;
    end else if (fire0) begin
      next1_ff <= next0_ff + 64'(cycle1);
      arm1_ff <= 1'b1;
    end else if (fire1 || !active_ff) begin
      arm1_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend0_ff <= 1'b0;
      pend1_ff <= 1'b0;
      plaus_ff <= 1'b0;
      force_ff <= 1'b0;
    end else if (active_rise) begin
      pend0_ff <= act_ctrl.first_sync_en;
      pend1_ff <= act_ctrl.second_sync_en;
      plaus_ff <= out_of_near;
      force_ff <= out_of_near && act_ctrl.plaus_check;
    end else begin
      pend0_ff <= pend0_ff && !fire0 && nxt_active;
      pend1_ff <= pend1_ff && !fire1 && nxt_active;
      force_ff <= force_ff && !fire0;
    end
  end

  // host read acknowledges in ack mode
  logic ack0;
  logic ack1;
  assign ack0 = host_req.rd && host_req.addr == dc_sync_pkg::ADDR_ACK0_STAT;
  assign ack1 = host_req.rd && host_req.addr == dc_sync_pkg::ADDR_ACK1_STAT;

  sync_pulse_shaper u_first (
    .clk(clk),
    .rst_n(rst_n),
    .sys_time(sys_time),
    .fire(fire0),
    .len_units(len_ff),
    .ack_clear(ack0),
    .level(first_sync_output)
  );
  sync_pulse_shaper u_second (
    .clk(clk),
    .rst_n(rst_n),
    .sys_time(sys_time),
    .fire(fire1),
    .len_units(len_ff),
    .ack_clear(ack1),
    .level(second_sync_output)
  );

  // start time reads back next pulse
  function automatic logic [7:0] read_byte(input logic [11:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a[11:1] == dc_sync_pkg::ADDR_PULSE_LEN[11:1]) begin
      r = a[0] ? len_ff[15:8] : len_ff[7:0];
    end else if (a == dc_sync_pkg::ADDR_ACT_STATUS) begin
      r = {5'h00, plaus_ff, pend1_ff, pend0_ff};
    end else if (a == dc_sync_pkg::ADDR_ACK0_STAT) begin
      r = {7'h00, first_sync_output};
    end else if (a == dc_sync_pkg::ADDR_ACK1_STAT) begin
      r = {7'h00, second_sync_output};
    end else if (a[11:3] == dc_sync_pkg::ADDR_START_TIME[11:3]) begin
      r = next0_ff[{a[2:0], 3'h0} +: 8];
    end else if (a[11:3] == dc_sync_pkg::ADDR_NEXT1_TIME[11:3]) begin
      r = next1_ff[{a[2:0], 3'h0} +: 8];
    end else if (a[11:2] == dc_sync_pkg::ADDR_CYCLE0[11:2]) begin
      r = cycle0[{a[1:0], 3'h0} +: 8];
    end else if (a[11:2] == dc_sync_pkg::ADDR_CYCLE1[11:2]) begin
      r = cycle1[{a[1:0], 3'h0} +: 8];
    end else if (a == dc_sync_pkg::ADDR_LATCH_CTRL) begin
      r = {6'h00, latch_ff};
    end
    return r;
  endfunction

  logic [7:0] net_rbyte;
  logic [7:0] host_rbyte;
  assign net_rbyte = read_byte(net_req.addr);
  assign host_rbyte = read_byte(host_req.addr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      net_rdata_ff <= 8'h00;
      host_rdata_ff <= 8'h00;
    end else begin
      if (net_req.rd) begin
        net_rdata_ff <= net_rbyte;
      end
      if (host_req.rd) begin
        host_rdata_ff <= host_rbyte;
      end
    end
  end

  assign net_rdata = net_rdata_ff;
  assign host_rdata = host_rdata_ff;
  assign unit_active = active_ff;
  assign latch_capture_mode = latch_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ack_hold: assert property (
    first_sync_output && len_ff == 16'h0000 && !ack0 && !fire0
    && !eeprom_len_load |=> first_sync_output)
    else $error("ack mode output dropped without read");
  a_ack_clear: assert property (
    ack0 && len_ff == 16'h0000 && !fire0 |=> !first_sync_output)
    else $error("status read did not clear output");
  a_len_ro: assert property (
    !eeprom_len_load |=> $stable(len_ff))
    else $error("pulse length changed without load");
  a_start_gate: assert property (
    sync_owner_host |=> $stable(start_sh))
    else $error("start time written under host ownership");
  a_cycle_gate: assert property (
    sync_owner_host && !host_req.wr |=> $stable(cycle0) && $stable(cycle1))
    else $error("cycle register written by non-owner");
  a_latch_gate: assert property (
    !latch_owner_host && !net_req.wr |=> $stable(latch_ff))
    else $error("latch control written by non-owner");
  a_next_adv: assert property (
    fire0 && !commit && cycle0 != 32'h0000_0000
    |=> next0_ff == $past(next0_ff) + 64'($past(cycle0)))
    else $error("next pulse time did not advance");
  a_single_shot: assert property (
    fire0 && !commit && cycle0 == 32'h0000_0000 |=> !fire0 [*2])
    else $error("single shot fired again");
  a_pend_clr: assert property (
    fire0 && !active_rise |=> !pend0_ff)
    else $error("pending bit kept after first pulse");
  a_auto_act: assert property (
    commit && act_ctrl.auto_act ##1 act_ctrl.auto_act |=> active_ff)
    else $error("auto activation did not activate unit");
  a_pulse_len: assert property (
    fire0 && len_ff != 16'h0000 |=> first_sync_output)
    else $error("timed pulse not asserted");
endmodule

// ### logic/dc_sync_pkg.sv
// Shared offsets, reset values and carriers for the sync pulse unit
package dc_sync_pkg;
  localparam logic [11:0] ADDR_PULSE_LEN = 12'h982;
  localparam logic [11:0] ADDR_ACT_STATUS = 12'h984;
  localparam logic [11:0] ADDR_ACK0_STAT = 12'h98E;
  localparam logic [11:0] ADDR_ACK1_STAT = 12'h98F;
  localparam logic [11:0] ADDR_START_TIME = 12'h990;
  localparam logic [11:0] ADDR_NEXT1_TIME = 12'h998;
  localparam logic [11:0] ADDR_CYCLE0 = 12'h9A0;
  localparam logic [11:0] ADDR_CYCLE1 = 12'h9A4;
  localparam logic [11:0] ADDR_LATCH_CTRL = 12'h9A8;
  localparam logic [15:0] PULSE_LEN_RST = 16'h0000;
  localparam logic [63:0] TIME_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] CYCLE_RST = 32'h0000_0000;
  localparam logic [1:0] LATCH_CTRL_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int ACT_PLAUS_BIT = 2;
  localparam int ACT_PEND1_BIT = 1;
  localparam int ACT_PEND0_BIT = 0;
  localparam int LATCH_NEG_BIT = 1;
  localparam int LATCH_POS_BIT = 0;
  localparam int LEN_UNIT_NS = 10;
  localparam logic [63:0] NEAR_SHORT_NS = 64'h0000_0000_8000_0000;
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic near_short;
    logic plaus_check;
    logic auto_act;
    logic second_sync_en;
    logic first_sync_en;
    logic activate;
  } act_ctrl_s;
endpackage

// ### logic/sync_pulse_shaper.sv
// One sync output: timed pulse or acknowledge-held level
`timescale 1ns/1ps
module sync_pulse_shaper (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [63:0] sys_time,
  input wire logic fire,
  input wire logic [15:0] len_units,
  input wire logic ack_clear,
  output logic level
);
  logic [63:0] end_ff;
  logic level_ff;
  logic [63:0] len_ns;
  logic [63:0] to_end;
  logic ack_mode;
  logic expired;
  assign len_ns = 64'(len_units) * 64'(dc_sync_pkg::LEN_UNIT_NS);
  assign to_end = sys_time - end_ff;
  assign ack_mode = (len_units == 16'h0000);
  assign expired = !to_end[63];
  assign level = level_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b0;
      end_ff <= dc_sync_pkg::TIME_RST;
    end else if (fire) begin
      level_ff <= 1'b1;
      end_ff <= sys_time + len_ns;
    end else if (!ack_mode && expired) begin
      level_ff <= 1'b0;
    end else if (ack_mode && ack_clear) begin
      level_ff <= 1'b0;
    end
  end
endmodule

// ### sim/reg_master.sv
// Byte-wide register access master for one side of the block
`timescale 1ns/1ps
module reg_master (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output dc_sync_pkg::reg_req_s req
);
  initial begin
    req = '0;
  end
  task automatic wr8(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{a, 1'b1, 1'b0, d};
    @(negedge clk);
    // Released lines show garbage, not the last value
    req = '{~a, 1'b0, 1'b0, ~d};
  endtask
  task automatic rd8(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk);
    req = '{~a, 1'b0, 1'b0, 8'h5A};
    d = rdata;
  endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the sync pulse and latch mode registers
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [63:0] sys_time = 64'h0;
  logic jump = 1'b0;
  logic [63:0] jump_to = 64'h0;
  dc_sync_pkg::reg_req_s net_req, host_req;
  logic net_frame_end = 1'b0;
  logic [7:0] net_rdata, host_rdata;
  logic sync_owner_host = 1'b0;
  logic latch_owner_host = 1'b0;
  dc_sync_pkg::act_ctrl_s act_ctrl = '0;
  logic eeprom_len_load = 1'b0;
  logic [15:0] eeprom_len = 16'h0000;
  logic first_sync_output, second_sync_output, unit_active;
  logic [1:0] latch_capture_mode;
  logic [1:0] outs;
  logic [7:0] mdl [int];
  int n_fail = 0;
  int n_compared = 0;
  int n_first = 0;
  int n_sec = 0;
  int seed = 32'h7AD5058D;
  int n;
  logic [63:0] t0;

  assign outs = {second_sync_output, first_sync_output};
  always #4 clk = ~clk;
  always @(negedge clk) sys_time <= jump ? jump_to : sys_time + 64'h8;
  always @(posedge first_sync_output) n_first++;
  always @(posedge second_sync_output) n_sec++;

  dc_sync_pulse_latch_regs u_dc_sync_pulse_latch_regs (.clk(clk),
    .nrst(nrst), .sys_time(sys_time), .net_req(net_req),
    .net_frame_end(net_frame_end), .net_rdata(net_rdata),
    .host_req(host_req), .host_rdata(host_rdata),
    .sync_owner_host(sync_owner_host),
    .latch_owner_host(latch_owner_host), .act_ctrl(act_ctrl),
    .eeprom_len_load(eeprom_len_load), .eeprom_len(eeprom_len),
    .first_sync_output(first_sync_output),
    .second_sync_output(second_sync_output), .unit_active(unit_active),
    .latch_capture_mode(latch_capture_mode));
  reg_master net_m (.clk(clk), .rdata(net_rdata), .req(net_req));
  reg_master host_m (.clk(clk), .rdata(host_rdata), .req(host_req));

  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] v);
    n_compared++;
    if (v !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, v);
    end
  endtask
  function automatic logic [63:0] mexp(input int a, input int nb);
    mexp = '0;
    for (int i = 0; i < nb; i++) begin
      mexp[8*i +: 8] = mdl[a + i];
    end
  endfunction
  // Model keeps only writes from the owning side
  task automatic wr(input bit h, input logic [11:0] a, input int nb,
                    input logic [63:0] d);
    for (int i = 0; i < nb; i++) begin
      if (h) host_m.wr8(a + 12'(i), d[8*i +: 8]);
      else net_m.wr8(a + 12'(i), d[8*i +: 8]);
      if (a >= 12'h9A0 && a < 12'h9A8 && h == sync_owner_host) begin
        mdl[a + i] = d[8*i +: 8];
      end
      if (a == 12'h9A8 && h == latch_owner_host) mdl[a] = {6'h00, d[1:0]};
    end
  endtask
  task automatic rdc(input string nm, input bit h, input logic [11:0] a,
                     input int nb, input logic [63:0] e);
    logic [7:0] b;
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < nb; i++) begin
      if (h) host_m.rd8(a + 12'(i), b);
      else net_m.rd8(a + 12'(i), b);
      v[8*i +: 8] = b;
    end
    chk(nm, e, v);
  endtask
  task automatic wait_out(input int w, input int lim);
    for (int i = 0; i < lim && outs[w] !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk("sync_rise", 64'h1, {63'h0, outs[w]});
  endtask
  task automatic strobe(input bit fe, input logic [15:0] len);
    @(negedge clk);
    eeprom_len = len;
    net_frame_end = fe;
    eeprom_len_load = ~fe;
    @(negedge clk);
    net_frame_end = 1'b0;
    eeprom_len_load = 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  initial begin
    for (int a = 'h9A0; a <= 'h9A8; a++) begin
      mdl[a] = 8'h00;
    end
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rdc("length", 0, dc_sync_pkg::ADDR_PULSE_LEN, 2, 64'h0); // reset
    rdc("start", 1, dc_sync_pkg::ADDR_START_TIME, 8, 64'h0); // reset
    rdc("next2", 0, dc_sync_pkg::ADDR_NEXT1_TIME, 8, 64'h0); // reset
    rdc("unmapped", 1, 12'h9A9, 1, 64'h0);
    for (int k = 0; k < 4; k++) begin
      sync_owner_host = k[0];
      latch_owner_host = k[1];
      wr(k[1], 12'h9A0, 4, 64'($random(seed))); // gating
      wr(k[0], 12'h9A4, 4, 64'($random(seed))); // gating
      wr(k[0], 12'h9A8, 1, 64'($random(seed))); // gating
      rdc("cycle0", k[0], 12'h9A0, 4, mexp('h9A0, 4)); // cycle
      rdc("cycle1", k[1], 12'h9A4, 4, mexp('h9A4, 4)); // delay
      rdc("latch", ~k[1], 12'h9A8, 1, mexp('h9A8, 1)); // modes
      chk("latch_mode", mdl['h9A8], 64'(latch_capture_mode));
    end
    sync_owner_host = 1'b0;
    strobe(0, 16'h0005);
    wr(0, dc_sync_pkg::ADDR_PULSE_LEN, 2, 64'hFFFF);
    rdc("length", 1, dc_sync_pkg::ADDR_PULSE_LEN, 2, 64'h5); // load
    wr(0, 12'h9A0, 4, 64'h320);
    wr(0, 12'h9A4, 4, 64'hC8);
    act_ctrl = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    jump_to = 64'h0000_0005_FFFF_FC00;
    jump <= 1'b1;
    @(negedge clk);
    jump <= 1'b0;
    // Low word wraps past the current one, so the upper word carries
    t0 = {32'h6, 32'hFFFF_FC00 + 32'h5DC + 32'($random(seed) & 32'h3FF)};
    wr(1, dc_sync_pkg::ADDR_START_TIME, 4, 64'h0); // host refused
    wr(0, dc_sync_pkg::ADDR_START_TIME, 4, t0); // start
    strobe(1, 16'h0);
    rdc("start", 1, dc_sync_pkg::ADDR_START_TIME, 8, t0); // extend
    chk("active", 64'h1, 64'(unit_active)); // auto
    rdc("status", 0, dc_sync_pkg::ADDR_ACT_STATUS, 1, 64'h3);
    wait_out(0, 600); // start
    chk("fire_at", 64'h1, 64'(sys_time - t0 < 64'h28));
    n = 0;
    while (first_sync_output === 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("width", 64'h1, 64'(n >= 6 && n <= 8)); // length
    rdc("next1", 0, dc_sync_pkg::ADDR_START_TIME, 8, t0 + 64'h320);
    rdc("next2", 1, dc_sync_pkg::ADDR_NEXT1_TIME, 8, t0 + 64'hC8);
    rdc("status", 1, dc_sync_pkg::ADDR_ACT_STATUS, 1, 64'h0);
    wr(0, 12'h9A0, 4, 64'h0);
    wait_out(0, 200); // repeat
    repeat (300) @(negedge clk);
    chk("first_count", 64'h2, 64'(n_first)); // one shot
    chk("second_count", 64'h2, 64'(n_sec)); // pairing
    strobe(0, 16'h0000);
    t0 = sys_time + 64'h190;
    wr(0, dc_sync_pkg::ADDR_START_TIME, 4, t0);
    strobe(1, 16'h0);
    wait_out(0, 200); // ack start
    wait_out(1, 60); // delay
    repeat (20) @(negedge clk);
    rdc("ack1", 0, dc_sync_pkg::ADDR_ACK0_STAT, 1, 64'h1); // net
    chk("held1", 64'h1, 64'(first_sync_output)); // hold
    rdc("ack1", 1, dc_sync_pkg::ADDR_ACK0_STAT, 1, 64'h1); // host
    rdc("ack2", 1, dc_sync_pkg::ADDR_ACK1_STAT, 1, 64'h1); // host
    chk("clear", 64'h0, 64'(outs)); // ack clear
    act_ctrl = '0;
    // Start far ahead, so only the plausibility check can fire it
    t0 = sys_time + 64'h0000_0001_0000_0000;
    wr(0, dc_sync_pkg::ADDR_START_TIME, 8, t0);
    sync_owner_host = 1'b1;
    wr(0, dc_sync_pkg::ADDR_START_TIME, 8, 64'h0); // refused
    sync_owner_host = 1'b0;
    strobe(1, 16'h0);
    act_ctrl = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    wait_out(0, 4); // forced pulse
    rdc("status", 0, dc_sync_pkg::ADDR_ACT_STATUS, 1, 64'h6);
    end_sim();
  end
endmodule
